// File: fbled_pkg.sv
/*
 * package for the fieldbus adapter status indicator block: indicator
 * timing constants, cyclic data budget, object identifiers and the
 * indicator pattern encodings shared by the design.
 * assumes a single 200 MHz clock and an active-low asynchronous reset.
 */
package fbled_pkg;

    // ------------------------------------------------------------------
    // clock and indicator timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ      = 200_000_000;
    localparam int BLINK_HALF_MS    = 500;  // slow blink half period
    localparam int ALT_HALF_MS      = 250;  // green/red alternate half period
    localparam int FLICK_HALF_MS    = 50;   // activity flicker half period
    localparam int BLINK_CYC  = (CLK_FREQ_HZ / 1000) * BLINK_HALF_MS;
    localparam int ALT_CYC    = (CLK_FREQ_HZ / 1000) * ALT_HALF_MS;
    localparam int FLICK_CYC  = (CLK_FREQ_HZ / 1000) * FLICK_HALF_MS;
    localparam int TICK_W     = 27;         // wide enough for BLINK_CYC
    localparam int ACT_HOLD_N = 4;          // flicker half periods held per burst

    // ------------------------------------------------------------------
    // cyclic data budget and object identifiers
    // ------------------------------------------------------------------
    localparam logic [10:0] CYC_DATA_MAX = 11'h5D0; // 1488 bytes
    localparam logic [15:0] OBJ_RESET     = 16'h1011;
    localparam logic [7:0]  OBJ_RESET_SUB = 8'h01;
    localparam logic [15:0] OBJ_FW_A      = 16'h20C0;
    localparam logic [15:0] OBJ_FW_B      = 16'h20C8;
    localparam logic [7:0]  OBJ_SUB_LO    = 8'h5C;  // subindex 92
    localparam logic [7:0]  OBJ_SUB_HI    = 8'h5F;  // subindex 95
    localparam int          NPORT         = 2;

    // ------------------------------------------------------------------
    // indicator pattern encoding
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FBLED_OFF     = 3'b000,
        FBLED_GRN     = 3'b001,
        FBLED_RED     = 3'b010,
        FBLED_GRN_BLK = 3'b011,
        FBLED_RED_BLK = 3'b100,
        FBLED_ALT     = 3'b101
    } fbled_pat_e;

endpackage

// File: fbled_top.sv
/*
 * status indicator logic of the fieldbus adapter: host link, module,
 * network and per-port link/activity indicators, plus the cyclic data
 * pipeline delay, budget check, persistent object guard and firmware
 * update request.
 * assumes status inputs come from asynchronous sources and are
 * synchronised here; the cyclic strobe, lengths, data, object and
 * revision inputs already run on the same clock. all outputs are
 * registered.
 */
module fbled_top (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              arst_n_i,
    // host link status
    input  wire logic              host_run_i,
    input  wire logic              boot_fail_i,
    // module status
    input  wire logic              mod_init_i,
    input  wire logic              mod_configured_i,
    input  wire logic              hw_fault_rec_i,
    input  wire logic              hw_fault_fatal_i,
    // network status
    input  wire logic              net_init_i,
    input  wire logic              ip_assigned_i,
    input  wire logic              ip_duplicate_i,
    input  wire logic              conn_active_i,
    input  wire logic              conn_timeout_i,
    // ethernet ports
    input  wire logic [1:0]        port_link_i,
    input  wire logic [1:0]        port_activity_i,
    // cyclic data, bus cycle strobe and sizes
    input  wire logic              bus_cycle_i,
    input  wire logic [10:0]       in_len_i,
    input  wire logic [10:0]       out_len_i,
    input  wire logic [31:0]       in_data_i,
    input  wire logic [31:0]       out_data_i,
    // object access from bus controller
    input  wire logic              obj_wr_i,
    input  wire logic [15:0]       obj_index_i,
    input  wire logic [7:0]        obj_sub_i,
    // firmware revisions
    input  wire logic [15:0]       fw_rev_i,
    input  wire logic [15:0]       proj_rev_i,
    input  wire logic              fw_done_i,
    // indicator outputs
    output logic                   host_grn_o,
    output logic                   host_red_o,
    output logic                   mod_grn_o,
    output logic                   mod_red_o,
    output logic                   net_grn_o,
    output logic                   net_red_o,
    output logic [1:0]             port_link_activity_led_o,
    // data and control outputs
    output logic [31:0]            in_data_o,
    output logic [31:0]            out_data_o,
    output logic                   len_err_o,
    output logic                   store_wr_o,
    output logic                   fw_update_o
);
    import fbled_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int NS = 13;
    logic [NS-1:0] s1_reg;
    logic [NS-1:0] s2_reg;
    wire  [NS-1:0] raw = {host_run_i, boot_fail_i, mod_init_i,
        mod_configured_i, hw_fault_rec_i, hw_fault_fatal_i, net_init_i,
        ip_assigned_i, ip_duplicate_i, conn_active_i, conn_timeout_i,
        port_activity_i[1], port_activity_i[0]};
    logic [1:0] lk1_reg;
    logic [1:0] lk2_reg;

    // two stage capture of asynchronous status levels
    // only the second stage feeds logic, so a metastable first stage
    // has a whole cycle to settle before anything decides on it
    // link and activity share the same two stage depth, so a port
    // indicator never sees activity ahead of its own link state
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            lk1_reg <= 2'h0;
            lk2_reg <= 2'h0;
        end else begin
            s1_reg  <= raw;
            s2_reg  <= s1_reg;
            lk1_reg <= port_link_i;
            lk2_reg <= lk1_reg;
        end
    end

    wire host_run  = s2_reg[12];
    wire boot_fail = s2_reg[11];
    wire mod_init  = s2_reg[10];
    wire mod_cfg   = s2_reg[9];
    wire flt_rec   = s2_reg[8];
    wire flt_fatal = s2_reg[7];
    wire net_init  = s2_reg[6];
    wire ip_ok     = s2_reg[5];
    wire ip_dup    = s2_reg[4];
    wire conn_act  = s2_reg[3];
    wire conn_to   = s2_reg[2];
    wire [1:0] act = s2_reg[1:0];

    // ------------------------------------------------------------------
    // rate dividers
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] blk_cnt_reg;
    logic [TICK_W-1:0] alt_cnt_reg;
    logic [TICK_W-1:0] flk_cnt_reg;
    logic              blk_ph_reg;
    logic              alt_ph_reg;
    logic              flk_ph_reg;
    wire blk_end = (blk_cnt_reg == TICK_W'(BLINK_CYC - 1));
    wire alt_end = (alt_cnt_reg == TICK_W'(ALT_CYC - 1));
    wire flk_end = (flk_cnt_reg == TICK_W'(FLICK_CYC - 1));

    // three free-running phases at distinct fixed rates
    // every phase starts low after reset, so blinking patterns open
    // with their dark half and the alternate pattern opens on red
    // the counters never stop, so patterns that share a rate stay in
    // step across all indicators
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blk_cnt_reg <= '0;
            alt_cnt_reg <= '0;
            flk_cnt_reg <= '0;
            blk_ph_reg  <= 1'b0;
            alt_ph_reg  <= 1'b0;
            flk_ph_reg  <= 1'b0;
        end else begin
            blk_cnt_reg <= blk_end ? '0 : blk_cnt_reg + TICK_W'(1);
            alt_cnt_reg <= alt_end ? '0 : alt_cnt_reg + TICK_W'(1);
            flk_cnt_reg <= flk_end ? '0 : flk_cnt_reg + TICK_W'(1);
            blk_ph_reg  <= blk_ph_reg ^ blk_end;
            alt_ph_reg  <= alt_ph_reg ^ alt_end;
            flk_ph_reg  <= flk_ph_reg ^ flk_end;
        end
    end

    // ------------------------------------------------------------------
    // pattern selection
    // ------------------------------------------------------------------
    // each indicator first picks one pattern from its status levels,
    // then one shared mapping turns the pattern into the two drives;
    // the order of the tests below is the priority between causes
    fbled_pat_e host_pat;
    fbled_pat_e mod_pat;
    fbled_pat_e net_pat;

    // host link: running wins, boot failure blinks, else steady red
    assign host_pat = host_run  ? FBLED_GRN :
                      boot_fail ? FBLED_RED_BLK :
                                  FBLED_RED;

    // module: fatal fault first, then recoverable, init, config, run
    assign mod_pat = flt_fatal ? FBLED_RED :
                     flt_rec   ? FBLED_RED_BLK :
                     mod_init  ? FBLED_ALT :
                     !mod_cfg  ? FBLED_GRN_BLK :
                                 FBLED_GRN;

    // network: init, no address, duplicate, timeout, connections
    // an unassigned address darkens the indicator before any fault
    assign net_pat = net_init  ? FBLED_ALT :
                     !ip_ok    ? FBLED_OFF :
                     ip_dup    ? FBLED_RED :
                     conn_to   ? FBLED_RED_BLK :
                     conn_act  ? FBLED_GRN :
                                 FBLED_GRN_BLK;

    // pattern to green/red drive
    // result is {green, red}; a dual indicator never lights both at
    // once, the alternate pattern swaps them on every alternate phase
    function automatic logic [1:0] pat_drive(input fbled_pat_e p,
                                             input logic blk,
                                             input logic alt);
        logic [1:0] gr;
        gr = 2'h0;
        unique case (p)
            FBLED_OFF:     gr = 2'h0;
            FBLED_GRN:     gr = 2'h2;
            FBLED_RED:     gr = 2'h1;
            FBLED_GRN_BLK: gr = {blk, 1'b0};
            FBLED_RED_BLK: gr = {1'b0, blk};
            FBLED_ALT:     gr = {alt, ~alt};
            default:       gr = 2'h0;
        endcase
        return gr;
    endfunction

    wire [1:0] host_gr = pat_drive(host_pat, blk_ph_reg, alt_ph_reg);
    wire [1:0] mod_gr  = pat_drive(mod_pat, blk_ph_reg, alt_ph_reg);
    wire [1:0] net_gr  = pat_drive(net_pat, blk_ph_reg, alt_ph_reg);

    // ------------------------------------------------------------------
    // port link/activity
    // ------------------------------------------------------------------
    logic [1:0] act_seen_reg;
    logic [2:0] act_hold_reg [NPORT];
    logic [1:0] port_led;

    // activity stretched over a few flicker periods per port
    // short bursts of traffic would otherwise end before a single
    // flicker phase passes and never show; losing the link clears the
    // hold at once so a dark port never starts out flickering
    generate
        for (genvar p = 0; p < NPORT; p++) begin : g_port
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    act_hold_reg[p] <= 3'h0;
                end else if (!lk2_reg[p]) begin
                    act_hold_reg[p] <= 3'h0;
                end else if (act[p]) begin
                    act_hold_reg[p] <= 3'(ACT_HOLD_N);
                end else if (flk_end && act_hold_reg[p] != 3'h0) begin
                    act_hold_reg[p] <= act_hold_reg[p] - 3'h1;
                end
            end
            assign act_seen_reg[p] = (act_hold_reg[p] != 3'h0);
            assign port_led[p] = !lk2_reg[p]     ? 1'b0 :
                                 act_seen_reg[p] ? flk_ph_reg :
                                                   1'b1;
        end
    endgenerate

    // ------------------------------------------------------------------
    // cyclic data, object guard, firmware
    // ------------------------------------------------------------------
    wire len_bad = (in_len_i > CYC_DATA_MAX) ||
                   (out_len_i > CYC_DATA_MAX);
    wire obj_persist = ((obj_index_i == OBJ_FW_A) ||
                        (obj_index_i == OBJ_FW_B)) &&
                       (obj_sub_i >= OBJ_SUB_LO) &&
                       (obj_sub_i <= OBJ_SUB_HI);
    wire obj_reset = (obj_index_i == OBJ_RESET) &&
                     (obj_sub_i == OBJ_RESET_SUB);
    // reset access never writes the store, only direct rewrites do
    // the guard decodes the address only; the stored image itself
    // sits outside this block and sees nothing but the write pulse
    wire store_wr = obj_wr_i && obj_persist && !obj_reset;
    wire fw_diff = (fw_rev_i != proj_rev_i);

    logic fw_upd_reg;

    // output registers, data moves one bus cycle per direction
    // lengths are judged only with the cycle strobe, so the error
    // flag describes the last frame taken and holds between frames
    // firmware request stays high while revisions differ and the
    // update has not reported completion
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_grn_o  <= 1'b0;
            host_red_o  <= 1'b0;
            mod_grn_o   <= 1'b0;
            mod_red_o   <= 1'b0;
            net_grn_o   <= 1'b0;
            net_red_o   <= 1'b0;
            port_link_activity_led_o <= 2'h0;
            in_data_o   <= 32'h0;
            out_data_o  <= 32'h0;
            len_err_o   <= 1'b0;
            store_wr_o  <= 1'b0;
            fw_upd_reg  <= 1'b0;
        end else begin
            {host_grn_o, host_red_o} <= host_gr;
            {mod_grn_o, mod_red_o}   <= mod_gr;
            {net_grn_o, net_red_o}   <= net_gr;
            port_link_activity_led_o <= port_led;
            if (bus_cycle_i) begin
                in_data_o  <= in_data_i;
                out_data_o <= out_data_i;
                len_err_o  <= len_bad;
            end
            store_wr_o <= store_wr;
            fw_upd_reg <= fw_diff && !fw_done_i;
        end
    end

    assign fw_update_o = fw_upd_reg;

endmodule

// File: fbled_chk.sv
/* concurrent checks on the status indicator block top ports.
 * assumes one clock domain and an active-low asynchronous reset. */
module fbled_chk
    import fbled_pkg::*;
(
    // clock and reset
    input wire logic        clock_i,
    input wire logic        arst_n_i,
    // watched inputs
    input wire logic        host_run_i,
    input wire logic [1:0]  port_link_i,
    input wire logic        bus_cycle_i,
    input wire logic [10:0] in_len_i,
    input wire logic [10:0] out_len_i,
    input wire logic [31:0] in_data_i,
    input wire logic [31:0] out_data_i,
    input wire logic        obj_wr_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0]  obj_sub_i,
    input wire logic [15:0] fw_rev_i,
    input wire logic [15:0] proj_rev_i,
    input wire logic        fw_done_i,
    // watched outputs
    input wire logic        host_grn_o,
    input wire logic [1:0]  port_link_activity_led_o,
    input wire logic [31:0] in_data_o,
    input wire logic [31:0] out_data_o,
    input wire logic        len_err_o,
    input wire logic        store_wr_o,
    input wire logic        fw_update_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // overrun, persistent object and firmware request decodes
    wire logic too_long = (in_len_i > CYC_DATA_MAX) ||
                          (out_len_i > CYC_DATA_MAX);
    wire logic fw_obj = (obj_index_i == OBJ_FW_A) ||
                        (obj_index_i == OBJ_FW_B);
    wire logic hit = fw_obj && obj_sub_i >= OBJ_SUB_LO &&
                     obj_sub_i <= OBJ_SUB_HI;
    wire logic differ = (fw_rev_i != proj_rev_i) && !fw_done_i;

    chk_len_budget: assert property (
        bus_cycle_i |=> len_err_o == $past(too_long)) else $error("len flag");
    chk_data_shift: assert property (
        bus_cycle_i |=> in_data_o == $past(in_data_i)
            && out_data_o == $past(out_data_i)) else $error("data shift");
    chk_data_hold: assert property (
        !bus_cycle_i |=> $stable(in_data_o) && $stable(out_data_o))
        else $error("data moved");
    chk_store_hit: assert property (
        obj_wr_i |=> store_wr_o == $past(hit)) else $error("store pulse");
    chk_store_idle: assert property (
        !obj_wr_i |=> !store_wr_o) else $error("stray store");
    chk_fw_follow: assert property (
        differ |=> fw_update_o) else $error("no update");
    chk_fw_same: assert property (
        fw_rev_i == proj_rev_i |=> !fw_update_o) else $error("bad update");
    chk_host_green: assert property (
        host_run_i [*3] |=> host_grn_o) else $error("host not green");
    chk_port_dark: assert property (
        !port_link_i[0] [*3] |=> !port_link_activity_led_o[0])
        else $error("port lit");
endmodule

// File: fbled_bc_model.sv
/* behavioural bus controller at the far side of the cyclic data and
 * object path; the bench calls its tasks, requests change on falling
 * edges and are taken on the next rising edge. */
module fbled_bc_model
    import fbled_pkg::*;
#(
    parameter int NMOD  = 1, // modules sharing one cyclic budget
    parameter int PLK_V = 2  // protocol generation in use
)(
    // clock from the bench
    input  wire logic   clock_i,
    // cyclic data and object requests
    output logic        bus_cycle_o,
    output logic [10:0] in_len_o,
    output logic [10:0] out_len_o,
    output logic [31:0] in_data_o,
    output logic [31:0] out_data_o,
    output logic        obj_wr_o,
    output logic [15:0] obj_index_o,
    output logic [7:0]  obj_sub_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // per-module share of the frame budget
    localparam int SHARE = int'(CYC_DATA_MAX) / NMOD;
    // strobes drop low; data lines and object index carry the inverse of their last value
    task automatic rest();
        bus_cycle_o = 1'b0;
        obj_wr_o = 1'b0;
        in_data_o = ~in_data_o;
        out_data_o = ~out_data_o;
        obj_index_o = ~obj_index_o;
    endtask
    initial begin
        {in_len_o, out_len_o, in_data_o, out_data_o} = '0;
        {obj_index_o, obj_sub_o} = '0;
        rest();
    end
    task automatic idle();
        @(negedge clock_i);
        rest();
    endtask
    task automatic xfer(input logic [10:0] il, ol, input logic [31:0] id, od);
        @(negedge clock_i);
        obj_wr_o = 1'b0;
        {bus_cycle_o, in_len_o, out_len_o} = {PLK_V == 2, il, ol};
        {in_data_o, out_data_o} = {id, od};
    endtask
    task automatic obj(input logic [15:0] ix, input logic [7:0] sb);
        @(negedge clock_i);
        bus_cycle_o = 1'b0;
        {obj_wr_o, obj_index_o, obj_sub_o} = {1'b1, ix, sb};
    endtask
endmodule

// File: fbled_tb_top.sv
/* self-checking bench for the status indicator block: indicator
 * patterns, cyclic data path, object guard and firmware request.
 * assumes the bus controller model drives the data and object path. */
module fbled_tb_top
    import fbled_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0, arst_n_i = 1'b0;
    logic host_run_i = 0, boot_fail_i = 0, mod_init_i = 0;
    logic mod_configured_i = 0, hw_fault_rec_i = 0, hw_fault_fatal_i = 0;
    logic net_init_i = 0, ip_assigned_i = 0, ip_duplicate_i = 0;
    logic conn_active_i = 0, conn_timeout_i = 0, fw_done_i = 0;
    logic [1:0] port_link_i = 2'h0, port_activity_i = 2'h0;
    logic [15:0] fw_rev_i = 16'h0000, proj_rev_i = 16'h0000;
    logic bus_cycle_i, obj_wr_i, len_err_o, store_wr_o, fw_update_o;
    logic [10:0] in_len_i, out_len_i, l1, l2;
    logic [31:0] in_data_i, out_data_i, in_data_o, out_data_o, d1, d2;
    logic [15:0] obj_index_i;
    logic [7:0] obj_sub_i;
    logic host_grn_o, host_red_o, mod_grn_o, mod_red_o, net_grn_o, net_red_o;
    logic [1:0] port_link_activity_led_o;
    logic take_d = 1'b0, take_o = 1'b0;
    logic [64:0] dq[$];
    logic sq[$];
    int miscompares = 0, check_count = 0;
    logic [15:0] idx[4] = '{OBJ_FW_A, OBJ_FW_B, OBJ_RESET, 16'h2000};
    logic [7:0] sub[5] = '{OBJ_RESET_SUB, 8'h5B, 8'h5C, 8'h5F, 8'h60};

    fbled_top dut (.clock_i, .arst_n_i, .host_run_i, .boot_fail_i,
        .mod_init_i, .mod_configured_i, .hw_fault_rec_i, .hw_fault_fatal_i,
        .net_init_i, .ip_assigned_i, .ip_duplicate_i, .conn_active_i,
        .conn_timeout_i, .port_link_i, .port_activity_i, .bus_cycle_i,
        .in_len_i, .out_len_i, .in_data_i, .out_data_i, .obj_wr_i,
        .obj_index_i, .obj_sub_i, .fw_rev_i, .proj_rev_i, .fw_done_i,
        .host_grn_o, .host_red_o, .mod_grn_o, .mod_red_o, .net_grn_o,
        .net_red_o, .port_link_activity_led_o, .in_data_o, .out_data_o,
        .len_err_o, .store_wr_o, .fw_update_o);
    fbled_bc_model bc (.clock_i, .bus_cycle_o(bus_cycle_i),
        .in_len_o(in_len_i), .out_len_o(out_len_i), .in_data_o(in_data_i),
        .out_data_o(out_data_i), .obj_wr_o(obj_wr_i),
        .obj_index_o(obj_index_i), .obj_sub_o(obj_sub_i));

    // ------------------------------------------------------------
    // comparison and verdict
    // ------------------------------------------------------------
    task automatic tally(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic cmp_data(input logic [64:0] e, g);
        tally(e === g, "data or length flag");
    endtask
    task automatic cmp_led(input logic [7:0] e, g);
        tally(e === g, "indicator pattern");
    endtask
    task automatic cmp_bit(input logic e, g);
        tally(e === g, "control flag");
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // sets the status levels, then compares all indicators
    task automatic led_case(input logic [12:0] s, input logic [7:0] e);
        @(negedge clock_i);
        {host_run_i, boot_fail_i, mod_init_i, mod_configured_i,
         hw_fault_rec_i, hw_fault_fatal_i, net_init_i, ip_assigned_i,
         ip_duplicate_i, conn_active_i, conn_timeout_i, port_link_i} = s;
        repeat (5) @(negedge clock_i);
        cmp_led(e, {host_grn_o, host_red_o, mod_grn_o, mod_red_o,
                    net_grn_o, net_red_o, port_link_activity_led_o});
    endtask

    // clock, watchdog and result watcher
    initial forever #2.5 clock_i = ~clock_i;
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        report_and_stop();
    end
    always @(posedge clock_i) begin
        take_d <= bus_cycle_i && arst_n_i;
        take_o <= obj_wr_i && arst_n_i;
    end
    always @(negedge clock_i) begin
        if (take_d && dq.size() > 0)
            cmp_data(dq.pop_front(),
                     {in_data_o, out_data_o, len_err_o});
        if (take_o && sq.size() > 0)
            cmp_bit(sq.pop_front(), store_wr_o);
    end

    // main sequence
    initial begin
        void'($urandom(32'h81a999b9));
        repeat (10) @(negedge clock_i);
        arst_n_i = 1'b1;
        led_case(13'h122B, 8'hAB);
        led_case(13'h02B0, 8'h54);
        led_case(13'h1201, 8'hA1);
        led_case(13'h0C43, 8'h17);
        led_case(13'h132C, 8'h80);
        port_activity_i = 2'h1;
        led_case(13'h0021, 8'h40);
        for (int k = 0; k < 24; k++) begin
            l1 = (k == 0) ? CYC_DATA_MAX + 11'h001 : 11'($urandom);
            if (k == 1) l1 = CYC_DATA_MAX;
            l2 = (k == 2) ? CYC_DATA_MAX + 11'h001
                          : 11'($urandom % (bc.SHARE + 1));
            d1 = $urandom;
            d2 = $urandom;
            dq.push_back({d1, d2,
                          (l1 > CYC_DATA_MAX) || (l2 > CYC_DATA_MAX)});
            bc.xfer(l1, l2, d1, d2);
            if (k % 7 == 6) bc.idle();
        end
        foreach (idx[j])
            foreach (sub[s]) begin
                sq.push_back(j < 2 && sub[s] >= OBJ_SUB_LO &&
                             sub[s] <= OBJ_SUB_HI);
                bc.obj(idx[j], sub[s]);
            end
        bc.idle();
        for (int k = 0; k < 4; k++) begin
            @(negedge clock_i);
            fw_rev_i = 16'($urandom);
            proj_rev_i = k[0] ? fw_rev_i : ~fw_rev_i;
            fw_done_i = (k == 2);
            @(negedge clock_i);
            cmp_bit(k == 0, fw_update_o);
        end
        repeat (3) @(negedge clock_i);
        report_and_stop();
    end
endmodule

bind fbled_top fbled_chk chk (
    .clock_i, .arst_n_i, .host_run_i, .port_link_i, .bus_cycle_i,
    .in_len_i, .out_len_i, .in_data_i, .out_data_i, .obj_wr_i,
    .obj_index_i, .obj_sub_i, .fw_rev_i, .proj_rev_i, .fw_done_i,
    .host_grn_o, .port_link_activity_led_o, .in_data_o, .out_data_o,
    .len_err_o, .store_wr_o, .fw_update_o
);
